// [logic/lbs_sram_regs.svh]
// register offsets, field positions and reset values of the sram base configuration
`ifndef LBS_SRAM_REGS_SVH
`define LBS_SRAM_REGS_SVH

// control-register space offsets
`define LBS_CFG0_OFS 12'hC04
`define LBS_CFG1_OFS 12'hC05

// field positions
`define LBS_BASE_HI 31
`define LBS_BASE_LO 16
`define LBS_WP_BIT 8
`define LBS_CI_BIT 5
`define LBS_SC_BIT 4
`define LBS_SD_BIT 3
`define LBS_UC_BIT 2
`define LBS_UD_BIT 1
`define LBS_V_BIT 0

// bits that store a value, all others reserved
`define LBS_CFG_DEF_MASK 32'hFFFF_C13F

// reset value of the valid bit
`define LBS_V_RST 1'b0

`endif

// [logic/lbs_sram_pkg.sv]
// types shared by the local bus sram
`default_nettype none
package lbs_sram_pkg;
    // access size on the local bus and the dma port
    typedef enum logic [1:0] {LBS_BYTE, LBS_WORD, LBS_LONG, LBS_RSVD} lbs_size_e;
endpackage
`default_nettype wire

// [logic/lbs_sram.sv]
// two-bank local bus sram with programmable base decode and a dma port on bank one
`include "lbs_sram_regs.svh"
`default_nettype none

// Behaviour
// R1: processor hits complete in one clock, acknowledged next cycle, no wait states.
// R2: each bank decodes hits against a base on any 64K boundary.
// R3: byte, word and longword accesses write only addressed byte lanes.
// R4: instruction fetches may run to cache and sram in the same cycle.
// R5: on a fetch hit sram data is returned and cache data discarded.
// R6: data supplied by the sram is never allocated into the cache.
// R7: only bank one answers the dma port; bank zero is processor only.
// R8: each bank is two arrays of 2048 lines of 16 bytes.
// R9: bank one halves let dma and cpu run together on different halves.
// R10: two base configuration registers, one per bank.
// R11: control-register moves write the base registers but never read them.
// R12: the debug port reads and writes both base registers.
// R13: reserved bits drop writes and read as zero from debug.
// R14: reset clears only the valid bit, other bits keep their value.
// R15: a bank answers only while valid and the base matches.
// R16: write with write protect set leaves memory unchanged, ends in error.
module lbs_sram
    import lbs_sram_pkg::*;
#(
    parameter int HALF_WORDS = 8192
)
(
    input wire logic sys_clk,
    input wire logic reset,
    // processor local bus
    input wire logic cpu_req,
    input wire logic cpu_wr,
    input wire logic cpu_ifetch,
    input wire logic cpu_super,
    input wire lbs_size_e cpu_size,
    input wire logic [31:0] cpu_addr,
    input wire logic [31:0] cpu_wdata,
    input wire logic [31:0] cache_rdata,
    output logic cpu_hit,
    output logic [31:0] cpu_rdata_q,
    output logic cpu_ack_q,
    output logic cpu_err_q,
    output logic cache_discard_q,
    output logic cache_no_alloc_q,
    // dma requester, bank one only
    input wire logic dma_req,
    input wire logic dma_wr,
    input wire lbs_size_e dma_size,
    input wire logic [31:0] dma_addr,
    input wire logic [31:0] dma_wdata,
    output logic dma_ready,
    output logic [31:0] dma_rdata_q,
    output logic dma_ack_q,
    output logic dma_err_q,
    // control-register move, write only
    input wire logic ctl_wr,
    input wire logic [11:0] ctl_addr,
    input wire logic [31:0] ctl_wdata,
    // debug module access
    input wire logic dbg_wr,
    input wire logic dbg_rd,
    input wire logic [11:0] dbg_addr,
    input wire logic [31:0] dbg_wdata,
    output logic [31:0] dbg_rdata_q
);

    localparam int IDX_W = $clog2(HALF_WORDS);

    // ---------------------------------------------------------------
    // helper functions
    // ---------------------------------------------------------------

    // byte enables, big-endian lanes: address 0 is bits 31:24
    function automatic logic [3:0] lane_en(input lbs_size_e size, input logic [1:0] a);
        logic [3:0] en;
        en = 4'h0;
        case (size)
            LBS_BYTE: en = 4'h8 >> a;
            LBS_WORD: en = a[1] ? 4'h3 : 4'hC;
            LBS_LONG: en = 4'hF;
            default: en = 4'h0;
        endcase
        return en;
    endfunction

    // base match and valid check of one bank
    function automatic logic base_hit(input logic v, input logic [31:0] cfg, input logic [31:0] a);
        return v && (a[`LBS_BASE_HI:`LBS_BASE_LO] == cfg[`LBS_BASE_HI:`LBS_BASE_LO]);
    endfunction

    // ---------------------------------------------------------------
    // base configuration registers
    // ---------------------------------------------------------------

    logic [1:0] cfg_v_q;
    logic [1:0] cfg_v_d;
    logic [31:0] cfg_rest_q [0:1];
    logic [31:0] cfg_rest_d [0:1];
    logic [31:0] cfg [0:1];
    logic [1:0] ctl_sel;
    logic [1:0] dbg_sel;
    logic [1:0] cfg_we;
    logic [31:0] cfg_wval;

    // register select, offsets decoded once per writer
    assign ctl_sel[0] = ctl_wr && (ctl_addr == `LBS_CFG0_OFS);
    assign ctl_sel[1] = ctl_wr && (ctl_addr == `LBS_CFG1_OFS);
    assign dbg_sel[0] = dbg_addr == `LBS_CFG0_OFS;
    assign dbg_sel[1] = dbg_addr == `LBS_CFG1_OFS;
    assign cfg_we[0] = ctl_sel[0] || (dbg_wr && dbg_sel[0]);
    assign cfg_we[1] = ctl_sel[1] || (dbg_wr && dbg_sel[1]);
    // R13: reserved bits dropped
    // the processor move wins when both writers hit in one cycle
    assign cfg_wval = (ctl_sel != 2'b00 ? ctl_wdata : dbg_wdata) & `LBS_CFG_DEF_MASK;

    genvar b;
    generate
        for (b = 0; b < 2; b++)
        begin : g_cfg
            // R10: one register per bank
            assign cfg_v_d[b] = cfg_we[b] ? cfg_wval[`LBS_V_BIT] : cfg_v_q[b];
            assign cfg_rest_d[b] = cfg_we[b] ? cfg_wval : cfg_rest_q[b];
            assign cfg[b] = {cfg_rest_q[b][31:1], cfg_v_q[b]};

            // R14: reset touches the valid bit only
            always_ff @(posedge sys_clk)
            begin
                if (reset)
                    cfg_v_q[b] <= `LBS_V_RST;
                else
                    cfg_v_q[b] <= cfg_v_d[b];
            end

            // remaining bits hold their value through reset
            always_ff @(posedge sys_clk)
            begin
                cfg_rest_q[b] <= cfg_rest_d[b];
            end
        end
    endgenerate

    // debug read port; control-register moves have no read path
    logic [31:0] dbg_rdata_d;
    // R12: debug readback
    // R11: no read path from the move port
    assign dbg_rdata_d = !dbg_rd ? dbg_rdata_q :
                         dbg_sel[0] ? cfg[0] & `LBS_CFG_DEF_MASK :
                         dbg_sel[1] ? cfg[1] & `LBS_CFG_DEF_MASK : 32'h0000_0000;

    always_ff @(posedge sys_clk)
    begin
        if (reset)
            dbg_rdata_q <= 32'h0000_0000;
        else
            dbg_rdata_q <= dbg_rdata_d;
    end

    // ---------------------------------------------------------------
    // processor decode
    // ---------------------------------------------------------------

    logic [1:0] cpu_type_mask;
    logic [1:0] cpu_bank_hit;
    logic cpu_bank;
    logic cpu_half;
    logic cpu_wp;
    logic cpu_go;
    logic cpu_wr_ok;
    logic [3:0] cpu_lanes;

    // a set mask bit hides the bank from that access type
    generate
        for (b = 0; b < 2; b++)
        begin : g_cpu_dec
            assign cpu_type_mask[b] = cpu_super ?
                (cpu_ifetch ? cfg[b][`LBS_SC_BIT] : cfg[b][`LBS_SD_BIT]) :
                (cpu_ifetch ? cfg[b][`LBS_UC_BIT] : cfg[b][`LBS_UD_BIT]);
            // R2: base decode
            // R15: valid and base match
            assign cpu_bank_hit[b] = base_hit(cfg[b][`LBS_V_BIT], cfg[b], cpu_addr) && !cpu_type_mask[b];
        end
    endgenerate

    // bank zero wins if software overlaps both windows
    assign cpu_bank = !cpu_bank_hit[0];
    assign cpu_hit = cpu_req && (cpu_bank_hit != 2'b00);
    assign cpu_go = cpu_hit;
    assign cpu_half = cpu_addr[15];
    assign cpu_wp = cfg[cpu_bank][`LBS_WP_BIT];
    // R16: protected writes blocked
    assign cpu_wr_ok = cpu_go && cpu_wr && !cpu_wp;
    // R3: addressed lanes only
    assign cpu_lanes = cpu_wr_ok ? lane_en(cpu_size, cpu_addr[1:0]) : 4'h0;

    // ---------------------------------------------------------------
    // dma decode, bank one only
    // ---------------------------------------------------------------

    logic dma_hit;
    logic dma_half;
    logic dma_conflict;
    logic dma_go;
    logic [3:0] dma_lanes;

    // R7: dma decodes bank one only
    assign dma_hit = dma_req && base_hit(cfg[1][`LBS_V_BIT], cfg[1], dma_addr);
    assign dma_half = dma_addr[15];
    // R9: only a same-half collision stalls dma
    assign dma_conflict = cpu_go && cpu_bank && (cpu_half == dma_half);
    assign dma_ready = !dma_conflict;
    assign dma_go = dma_hit && !dma_conflict;
    assign dma_lanes = (dma_go && dma_wr && !cfg[1][`LBS_WP_BIT]) ? lane_en(dma_size, dma_addr[1:0]) : 4'h0;

    // ---------------------------------------------------------------
    // storage: two banks of two half arrays
    // ---------------------------------------------------------------

    logic [31:0] arr_rd [0:3];

    genvar h;
    generate
        for (b = 0; b < 2; b++)
        begin : g_bank
            for (h = 0; h < 2; h++)
            begin : g_half
                // R8: each half is 2048 lines of 16 bytes
                logic [31:0] mem [0:HALF_WORDS-1];
                logic cpu_own;
                logic dma_own;
                logic [IDX_W-1:0] idx;
                logic [3:0] we;
                logic [31:0] wdat;

                assign cpu_own = cpu_go && (cpu_bank == 1'(b)) && (cpu_half == 1'(h));
                // R9: dma takes the half that the cpu leaves free
                assign dma_own = (b == 1) && dma_go && (dma_half == 1'(h));
                assign idx = cpu_own ? cpu_addr[IDX_W+1:2] : dma_addr[IDX_W+1:2];
                assign we = cpu_own ? cpu_lanes : (dma_own ? dma_lanes : 4'h0);
                assign wdat = cpu_own ? cpu_wdata : dma_wdata;
                assign arr_rd[b*2+h] = mem[idx];

                // byte lanes of one word; a single process owns the whole array
                always_ff @(posedge sys_clk)
                begin
                    for (int j = 0; j < 4; j++)
                    begin
                        if (we[j])
                            mem[idx][j*8 +: 8] <= wdat[j*8 +: 8];
                    end
                end
            end
        end
    endgenerate

    // ---------------------------------------------------------------
    // processor answer
    // ---------------------------------------------------------------

    logic [31:0] cpu_word;
    logic [31:0] cpu_rdata_d;
    logic cpu_err_d;
    logic fetch_hit;

    assign cpu_word = arr_rd[{cpu_bank, cpu_half}];
    assign fetch_hit = cpu_go && cpu_ifetch && !cpu_wr;
    // R4: fetch runs alongside the cache
    // R5: sram data replaces the cache data
    assign cpu_rdata_d = (cpu_go && !cpu_wr) ? cpu_word : (cpu_req && cpu_ifetch ? cache_rdata : cpu_rdata_q);
    assign cpu_err_d = cpu_go && cpu_wr && cpu_wp;

    // R1: registered answer one cycle after the request
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            cpu_ack_q <= 1'b0;
            cpu_err_q <= 1'b0;
            cpu_rdata_q <= 32'h0000_0000;
            cache_discard_q <= 1'b0;
            cache_no_alloc_q <= 1'b0;
        end
        else
        begin
            cpu_ack_q <= cpu_go && !cpu_err_d;
            // R16: protected write ends in error
            cpu_err_q <= cpu_err_d;
            cpu_rdata_q <= cpu_rdata_d;
            // R5: cache data thrown away
            cache_discard_q <= fetch_hit;
            // R6: never allocate sram data
            cache_no_alloc_q <= cpu_go && !cpu_wr;
        end
    end

    // ---------------------------------------------------------------
    // dma answer
    // ---------------------------------------------------------------

    logic [31:0] dma_rdata_d;
    logic dma_err_d;

    assign dma_rdata_d = (dma_go && !dma_wr) ? arr_rd[{1'b1, dma_half}] : dma_rdata_q;
    assign dma_err_d = dma_go && dma_wr && cfg[1][`LBS_WP_BIT];

    // one-cycle answer once the half is free
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            dma_ack_q <= 1'b0;
            dma_err_q <= 1'b0;
            dma_rdata_q <= 32'h0000_0000;
        end
        else
        begin
            dma_ack_q <= dma_go && !dma_err_d;
            dma_err_q <= dma_err_d;
            dma_rdata_q <= dma_rdata_d;
        end
    end

endmodule

`default_nettype wire

// [verification/lbs_sram_chk.sv]
// port assertions for the local bus sram
`default_nettype none
module lbs_sram_chk (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic cpu_req,
    input wire logic cpu_wr,
    input wire logic cpu_ifetch,
    input wire logic cpu_hit,
    input wire logic cpu_ack_q,
    input wire logic cpu_err_q,
    input wire logic cache_discard_q,
    input wire logic cache_no_alloc_q,
    input wire logic dma_req,
    input wire logic dma_ready,
    input wire logic dma_ack_q,
    input wire logic dbg_rd,
    input wire logic [31:0] dbg_rdata_q
);
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (reset);
    // ------------------------------------------------
    // answers tied to the request one cycle earlier
    // ------------------------------------------------
    a_ack_one_cycle: assert property (cpu_req && cpu_hit |=> cpu_ack_q || cpu_err_q)
        else $error("hit not answered next cycle");
    a_miss_silent: assert property (!(cpu_req && cpu_hit) |=> !cpu_ack_q && !cpu_err_q)
        else $error("answer without a hit");
    a_err_on_write: assert property (cpu_err_q |-> $past(cpu_req && cpu_hit && cpu_wr))
        else $error("error without a write hit");
    a_discard_fetch: assert property (cache_discard_q == $past(cpu_req && cpu_hit && cpu_ifetch && !cpu_wr))
        else $error("cache discard wrong");
    a_read_no_alloc: assert property (cpu_req && cpu_hit && !cpu_wr |=> cache_no_alloc_q)
        else $error("sram read not marked");
    a_dma_taken: assert property (dma_ack_q |-> $past(dma_req && dma_ready))
        else $error("dma answered while not taken");
    a_reset_quiet: assert property ($past(reset) |-> !cpu_hit && !cpu_ack_q && !dma_ack_q)
        else $error("bank live after reset");
    a_dbg_rsvd_zero: assert property ($past(dbg_rd) |-> (dbg_rdata_q & 32'h0000_3EC0) == 32'h0)
        else $error("reserved bits read nonzero");
endmodule
bind lbs_sram lbs_sram_chk i_chk (.*);
`default_nettype wire

// [verification/lbs_dma_model.sv]
// dma controller stand-in, longword transfers only
`default_nettype none
module lbs_dma_model
    import lbs_sram_pkg::*;
(
    input wire logic sys_clk,
    input wire logic dma_ready,
    output logic dma_req,
    output logic dma_wr,
    output var lbs_size_e dma_size,
    output logic [31:0] dma_addr,
    output logic [31:0] dma_wdata
);
    // idle until a transfer is asked for
    initial
    begin
        {dma_req, dma_wr, dma_addr, dma_wdata} = '0;
        dma_size = LBS_LONG;
    end
    // one transfer; bounded wait so a refused request cannot hang
    task automatic xfer(input logic w, input logic [31:0] a, d);
        int n;
        n = 0;
        @(negedge sys_clk);
        {dma_req, dma_wr, dma_addr, dma_wdata} = {1'h1, w, a, d};
        @(posedge sys_clk);
        while (!dma_ready && n < 16)
        begin
            n++;
            @(posedge sys_clk);
        end
        @(negedge sys_clk);
        // released lines carry no stale value
        {dma_req, dma_addr, dma_wdata} = {1'h0, ~a, ~d};
    endtask
endmodule
`default_nettype wire

// [verification/lbs_sram_tb.sv]
// self-checking bench for the local bus sram
`default_nettype none
module lbs_sram_tb import lbs_sram_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk, reset, cpu_req, cpu_wr, cpu_ifetch, cpu_super, cpu_hit, cpu_ack_q, cpu_err_q;
    logic cache_discard_q, cache_no_alloc_q, dma_req, dma_wr, dma_ready, dma_ack_q, dma_err_q;
    logic ctl_wr, dbg_wr, dbg_rd, hit_seen;
    lbs_size_e cpu_size, dma_size, s;
    logic [1:0] ln;
    logic [11:0] ctl_addr, dbg_addr;
    logic [31:0] cpu_addr, cpu_wdata, cache_rdata, cpu_rdata_q, dma_addr, dma_wdata, dma_rdata_q;
    logic [31:0] ctl_wdata, dbg_wdata, dbg_rdata_q, b0, b1, a, d0, d1;
    int err_total = 0;
    int n_tests = 0;
    lbs_sram i_dut (.*);
    lbs_dma_model i_dma (.*);
    // ------------------------------------------------
    // helpers
    // ------------------------------------------------
    task automatic chk(input string n, input logic [31:0] seen, exp);
        n_tests++;
        if (seen !== exp)
        begin
            err_total++;
            $display("BAD %s exp %h seen %h", n, exp, seen);
        end
    endtask
    task automatic cpu(input logic w, f, input lbs_size_e sz, input logic [31:0] ad, wd);
        @(negedge sys_clk);
        {cpu_req, cpu_wr, cpu_ifetch, cpu_addr, cpu_wdata} = {1'h1, w, f, ad, wd};
        cpu_size = sz;
        #1 hit_seen = cpu_hit;
        @(negedge sys_clk);
        cpu_req = 1'h0;
    endtask
    // k picks ctl write, dbg write, dbg read
    task automatic cfg(input logic [2:0] k, input logic [11:0] ad, input logic [31:0] wd);
        @(negedge sys_clk);
        {ctl_wr, dbg_wr, dbg_rd, ctl_addr, dbg_addr, ctl_wdata, dbg_wdata} = {k, ad, ad, wd, wd};
        @(negedge sys_clk);
        {ctl_wr, dbg_wr, dbg_rd} = 3'h0;
    endtask
    // big-endian lane merge of a sized write
    function automatic logic [31:0] merge(logic [31:0] o, n, lbs_size_e sz, logic [1:0] l);
        logic [31:0] m;
        m = sz == LBS_BYTE ? 32'hFF00_0000 : sz == LBS_WORD ? 32'hFFFF_0000 : 32'hFFFF_FFFF;
        m = m >> (sz == LBS_LONG ? 0 : sz == LBS_WORD ? 16 * l[1] : 8 * l);
        return (o & ~m) | (n & m);
    endfunction
    task automatic stop_test;
        $display("tests %0d errors %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // 50 ns clock
    initial
    begin
        sys_clk = 1'h0;
        forever #25 sys_clk = ~sys_clk;
    end
    // run needs some 20 us, so 1 ms means a hang
    initial
    begin
        #1000000;
        err_total++;
        stop_test;
    end
    // ------------------------------------------------
    // scenarios
    // ------------------------------------------------
    initial
    begin
        void'($urandom(59879));
        {reset, cpu_req, cpu_wr, cpu_ifetch, cpu_super, ctl_wr, dbg_wr, dbg_rd} = 8'h90;
        {cpu_addr, cpu_wdata, cache_rdata, ctl_addr, dbg_addr, ctl_wdata, dbg_wdata} = '0;
        cpu_size = LBS_LONG;
        repeat (16) @(negedge sys_clk);
        reset = 1'h0;
        b0 = {16'($urandom), 16'h0001};
        b1 = b0 ^ 32'h8000_0000;
        cfg(3'h4, 12'hC04, b0);
        cfg(3'h2, 12'hC05, 32'hFFFF_FFFF);
        cfg(3'h1, 12'hC05, 32'h0);
        chk("rsvd", dbg_rdata_q, 32'hFFFF_C13F);
        cfg(3'h4, 12'hC05, b1);
        // random sized writes, read back whole
        for (int i = 0; i < 40; i++)
        begin
            s = lbs_size_e'($urandom % 3);
            a = (b0 & 32'hFFFF_0000) | ($urandom & 32'h0000_FFFC);
            {d0, d1} = {$urandom, $urandom};
            ln = s == LBS_LONG ? 2'h0 : 2'($urandom);
            cpu(1'h1, 1'h0, LBS_LONG, a, d0);
            cpu(1'h1, 1'h0, s, a | ln, d1);
            chk("ack", cpu_ack_q, 1'h1);
            cpu(1'h0, 1'h0, LBS_LONG, a, 32'h0);
            chk("lanes", cpu_rdata_q, merge(d0, d1, s, ln));
        end
        d0 = merge(d0, d1, s, ln);
        cfg(3'h4, 12'hC04, b0 | 32'h0000_0100);
        cpu(1'h1, 1'h0, LBS_LONG, a, ~d0);
        chk("wp_err", cpu_err_q, 1'h1);
        cfg(3'h4, 12'hC04, b0);
        cache_rdata = ~d0;
        cpu(1'h0, 1'h1, LBS_LONG, a, 32'h0);
        chk("wp_keep", cpu_rdata_q, d0);
        chk("discard", cache_discard_q, 1'h1);
        chk("no_alloc", cache_no_alloc_q, 1'h1);
        cpu(1'h0, 1'h1, LBS_LONG, a ^ 32'h0100_0000, 32'h0);
        chk("miss", hit_seen, 1'h0);
        chk("pass", cpu_rdata_q, cache_rdata);
        cfg(3'h4, 12'hC04, b0 ^ 32'h0010_0000);
        cpu(1'h0, 1'h0, LBS_LONG, a ^ 32'h0010_0000, 32'h0);
        chk("moved", cpu_rdata_q, d0);
        cpu(1'h0, 1'h0, LBS_LONG, a, 32'h0);
        chk("old_base", hit_seen, 1'h0);
        // user data mask hides bank zero, supervisor still hits
        cfg(3'h4, 12'hC04, b0 ^ 32'h0010_0002);
        cpu(1'h0, 1'h0, LBS_LONG, a ^ 32'h0010_0000, 32'h0);
        chk("masked", hit_seen, 1'h0);
        cpu_super = 1'h1;
        cpu(1'h0, 1'h0, LBS_LONG, a ^ 32'h0010_0000, 32'h0);
        chk("super", cpu_rdata_q, d0);
        cpu_super = 1'h0;
        // dma with cpu on other then same half
        for (int sh = 0; sh < 2; sh++)
        begin
            d0 = $urandom;
            fork
                i_dma.xfer(1'h1, b1 | (sh ? 32'h0 : 32'h8000), d0);
                begin
                    cpu(1'h1, 1'h0, LBS_LONG, b1 | 32'h4, d1);
                    chk("dma_conc", dma_ack_q, 1'(!sh));
                end
            join
            chk("dma_ack", dma_ack_q, 1'h1);
            cpu(1'h0, 1'h0, LBS_LONG, b1 | (sh ? 32'h0 : 32'h8000), 32'h0);
            chk("dma_data", cpu_rdata_q, d0);
            i_dma.xfer(1'h0, b1 | (sh ? 32'h0 : 32'h8000), 32'h0);
            chk("dma_rd", dma_rdata_q, d0);
        end
        i_dma.xfer(1'h0, a ^ 32'h0010_0000, 32'h0);
        chk("dma_bank0", dma_ack_q, 1'h0);
        // protected dma write errors and leaves the word alone
        cfg(3'h4, 12'hC05, b1 | 32'h0000_0100);
        i_dma.xfer(1'h1, b1, ~d0);
        chk("dma_wp", dma_err_q, 1'h1);
        cfg(3'h4, 12'hC05, b1);
        i_dma.xfer(1'h0, b1, 32'h0);
        chk("dma_keep", dma_rdata_q, d0);
        @(negedge sys_clk);
        reset = 1'h1;
        repeat (2) @(negedge sys_clk);
        reset = 1'h0;
        cfg(3'h1, 12'hC05, 32'h0);
        chk("rst_keep", dbg_rdata_q, b1 & 32'hFFFF_FFFE);
        cpu(1'h0, 1'h0, LBS_LONG, b1, 32'h0);
        chk("rst_off", hit_seen, 1'h0);
        stop_test;
    end
endmodule
`default_nettype wire
